// file: rtl/lcg_cell_group.sv
// ten-cell logic group with carry-select arithmetic, chains and a wishbone configuration port
`timescale 1ns/100ps
module lcg_cell_group (
    input wire logic i_mclk,
    input wire logic i_rstn,
    input wire logic i_wb_cyc,
    input wire logic i_wb_stb,
    input wire logic i_wb_we,
    input wire logic [7:0] i_wb_adr,
    input wire logic [31:0] i_wb_dat,
    input wire logic [3:0] i_wb_sel,
    output logic [31:0] o_wb_dat,
    output logic o_wb_ack,
    input wire lcg_pkg::lcg_cell_in_type [lcg_pkg::NUM_CELLS-1:0] i_cell_data,
    input wire lcg_pkg::lcg_ctrl_type i_group_ctrl,
    input wire logic i_group_carry_in,
    input wire logic i_reg_chain_in,
    input wire logic i_lut_chain_in,
    input wire logic i_device_wide_clear_n,
    output logic [lcg_pkg::NUM_CELLS-1:0] o_cell_q,
    output logic [lcg_pkg::NUM_CELLS-1:0] o_cell_comb,
    output logic o_carry_out,
    output logic o_lut_chain_out,
    output logic o_reg_chain_out
);

    lcg_pkg::lcg_state_type st;
    lcg_pkg::lcg_state_type next_st;

    // working values of the combinational pass
    logic sel;
    logic c0;
    logic c1;
    logic cy;
    logic a;
    logic b;
    logic gen0;
    logic gen1;
    logic comb;
    logic lut;
    logic prev_lut;
    logic prev_q;
    logic d;
    logic tick;
    logic aclr;
    logic dev_clr;
    logic [3:0] lut_idx;
    logic [3:0] slot;
    logic [31:0] wr;

    // reference values read only by the checks below
    logic [lcg_pkg::NUM_CELLS-1:0] cell_tick;
    logic [lcg_pkg::NUM_CELLS-1:0] cell_aclr;
    logic [lcg_pkg::NUM_CELLS-1:0] vec_a;
    logic [lcg_pkg::NUM_CELLS-1:0] vec_b;
    logic [lcg_pkg::NUM_CELLS-1:0] add_sum;
    logic [lcg_pkg::NUM_CELLS-1:0] sub_sum;
    logic add_cout;
    logic lut1_ref;

    // byte-lane merge of a bus write into the stored word
    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] dat, input logic [3:0] be);
        logic [31:0] res;
        begin
            res = old;
            for (int k = 0; k < 4; k++) begin
                if (be[k]) begin
                    res[k*8 +: 8] = dat[k*8 +: 8];
                end
            end
            merge = res;
        end
    endfunction : merge

    // lookup mask slot for an address, LUT_NONE when outside the mask window or unaligned
    function automatic logic [3:0] lut_slot(input logic [7:0] adr);
        logic [7:0] off;
        begin
            off = adr - lcg_pkg::ADDR_LUT_BASE;
            lut_slot = lcg_pkg::LUT_NONE;
            if (adr >= lcg_pkg::ADDR_LUT_BASE && adr < lcg_pkg::ADDR_STATUS && adr[1:0] == 2'h0) begin
                lut_slot = off[5:2];
            end
        end
    endfunction : lut_slot

    function automatic logic [31:0] pack3(input logic [9:0] x, input logic [9:0] y, input logic [9:0] z);
        pack3 = {2'h0, z, y, x};
    endfunction : pack3

    // read decode; unmapped addresses answer zero
    function automatic logic [31:0] read_word(input lcg_pkg::lcg_state_type s, input logic [7:0] adr);
        logic [3:0] ls;
        begin
            ls = lut_slot(adr);
            read_word = 32'h0;
            case (adr)
                lcg_pkg::ADDR_CTRL: read_word[lcg_pkg::CTRL_DEVCLR_BIT] = s.cfg.dev_clr_en;
                lcg_pkg::ADDR_MODE: read_word = pack3(s.cfg.arith, s.cfg.lut_carry, s.cfg.clk_sel_b);
                lcg_pkg::ADDR_SOURCE: read_word = pack3(s.cfg.reg_chain, s.cfg.counter, s.cfg.aclr_sel_b);
                lcg_pkg::ADDR_CHAIN: read_word = pack3(s.cfg.chain_start, s.cfg.lut_chain, 10'h000);
                lcg_pkg::ADDR_STATUS: begin
                    read_word[lcg_pkg::FLD_A +: lcg_pkg::FLD_W] = s.q;
                    read_word[lcg_pkg::STAT_CARRY_BIT] = s.carry_out;
                    read_word[lcg_pkg::STAT_DEVCLR_BIT] = s.cfg.dev_clr_en & ~s.dclr_n;
                end
                default: begin
                    if (ls != lcg_pkg::LUT_NONE) begin
                        read_word[lcg_pkg::LUT_W-1:0] = s.cfg.lut_mask[ls];
                    end
                end
            endcase
        end
    endfunction : read_word

    // whole next state: cell datapath, register controls, pin synchroniser and bus slave
    always_comb begin : next_state_proc
        next_st = st;
        sel = i_group_carry_in;
        c0 = 1'b0;
        c1 = 1'b1;
        cy = 1'b0;
        a = 1'b0;
        b = 1'b0;
        gen0 = 1'b0;
        gen1 = 1'b0;
        comb = 1'b0;
        lut = 1'b0;
        prev_lut = i_lut_chain_in;
        prev_q = i_reg_chain_in;
        d = 1'b0;
        tick = 1'b0;
        aclr = 1'b0;
        lut_idx = 4'h0;
        slot = lcg_pkg::LUT_NONE;
        wr = 32'h0;
        cell_tick = '0;
        cell_aclr = '0;
        vec_a = '0;
        vec_b = '0;
        dev_clr = st.cfg.dev_clr_en & ~st.dclr_n; // RULE_20 RULE_23

        // pin synchroniser: the filtered level only moves when stages two and three agree
        next_st.dclr_sync = {st.dclr_sync[1:0], i_device_wide_clear_n};
        if (st.dclr_sync[1] == st.dclr_sync[2]) begin
            next_st.dclr_n = st.dclr_sync[2];
        end

        // ten cells in carry order, lowest first
        for (int i = 0; i < lcg_pkg::NUM_CELLS; i++) begin // RULE_21
            if (st.cfg.chain_start[i]) begin
                // subtract forces a one into the chain's first cell; counters feed their direction
                sel = st.cfg.counter[i] ? i_cell_data[i].second_data_input
                                        : (~i_group_ctrl.add_sub | i_group_carry_in); // RULE_02 RULE_03 RULE_12
                c0 = 1'b0;
                c1 = 1'b1;
            end else if (i == lcg_pkg::REGEN_CELL) begin
                // rebuilding here keeps only two selects on the critical path
                sel = sel ? c1 : c0; // RULE_11
                c0 = 1'b0;
                c1 = 1'b1;
            end
            cy = sel ? c1 : c0; // RULE_09
            a = st.cfg.counter[i] ? st.q[i] : i_cell_data[i].first_data_input; // RULE_15
            b = st.cfg.counter[i] ? ~i_cell_data[i].second_data_input
                                  : (i_cell_data[i].second_data_input ^ ~i_group_ctrl.add_sub); // RULE_01 RULE_17
            gen0 = a & b; // RULE_08
            gen1 = a | b;
            comb = cy ? ~(a ^ b) : (a ^ b); // RULE_08 RULE_09
            c0 = c0 ? gen1 : gen0; // RULE_10
            c1 = c1 ? gen1 : gen0; // RULE_10
            lut_idx = {st.cfg.lut_carry[i] ? cy : i_cell_data[i].fourth_data_input,
                       i_cell_data[i].third_data_input,
                       i_cell_data[i].second_data_input,
                       st.cfg.lut_chain[i] ? prev_lut : i_cell_data[i].first_data_input}; // RULE_04 RULE_05
            lut = st.cfg.lut_mask[i][lut_idx];
            if (!st.cfg.arith[i]) begin
                comb = lut;
            end
            prev_lut = lut; // RULE_05
            d = st.cfg.reg_chain[i] ? prev_q : comb; // RULE_06 RULE_14
            prev_q = st.q[i];
            tick = st.cfg.clk_sel_b[i] ? (i_group_ctrl.group_clock_b & i_group_ctrl.group_clock_enable_b)
                                       : (i_group_ctrl.group_clock_a & i_group_ctrl.group_clock_enable_a); // RULE_22
            aclr = st.cfg.aclr_sel_b[i] ? i_group_ctrl.async_clear_b : i_group_ctrl.async_clear_a; // RULE_19
            // level controls act every cycle regardless of the group clock
            if (dev_clr) begin
                next_st.q[i] = 1'b0; // RULE_20
            end else if (aclr) begin
                next_st.q[i] = 1'b0; // RULE_18
            end else if (i_group_ctrl.async_load) begin
                next_st.q[i] = i_cell_data[i].fourth_data_input; // RULE_07 RULE_18
            end else if (tick) begin
                if (i_group_ctrl.sync_clear) begin
                    next_st.q[i] = 1'b0; // RULE_16 RULE_24
                end else if (i_group_ctrl.sync_load) begin
                    next_st.q[i] = i_cell_data[i].fourth_data_input; // RULE_16 RULE_17
                end else if (!(st.cfg.counter[i] && st.cfg.arith[i] && !i_cell_data[i].third_data_input)) begin
                    next_st.q[i] = d; // RULE_14 RULE_15
                end
            end
            next_st.comb[i] = comb; // RULE_14
            cell_tick[i] = tick;
            cell_aclr[i] = aclr;
            vec_a[i] = i_cell_data[i].first_data_input;
            vec_b[i] = i_cell_data[i].second_data_input;
        end
        next_st.carry_out = sel ? c1 : c0; // RULE_12 RULE_13
        next_st.lut_chain_out = prev_lut;

        {add_cout, add_sum} = {1'b0, vec_a} + {1'b0, vec_b} + {10'h000, i_group_carry_in};
        sub_sum = vec_a - vec_b;
        lut1_ref = st.cfg.lut_mask[1][{i_cell_data[1].fourth_data_input, i_cell_data[1].third_data_input,
                                       i_cell_data[1].second_data_input, i_cell_data[1].first_data_input}];

        // bus slave: one-cycle registered ack, write lands on the acking edge
        next_st.ack = 1'b0;
        if (i_wb_cyc && i_wb_stb && !st.ack) begin
            next_st.ack = 1'b1;
            next_st.rdata = read_word(st, i_wb_adr);
            if (i_wb_we) begin
                slot = lut_slot(i_wb_adr);
                case (i_wb_adr)
                    lcg_pkg::ADDR_CTRL: begin
                        wr = merge({31'h0, st.cfg.dev_clr_en}, i_wb_dat, i_wb_sel);
                        next_st.cfg.dev_clr_en = wr[lcg_pkg::CTRL_DEVCLR_BIT];
                    end
                    lcg_pkg::ADDR_MODE: begin
                        wr = merge(pack3(st.cfg.arith, st.cfg.lut_carry, st.cfg.clk_sel_b), i_wb_dat, i_wb_sel);
                        next_st.cfg.arith = wr[lcg_pkg::FLD_A +: lcg_pkg::FLD_W];
                        next_st.cfg.lut_carry = wr[lcg_pkg::FLD_B +: lcg_pkg::FLD_W];
                        next_st.cfg.clk_sel_b = wr[lcg_pkg::FLD_C +: lcg_pkg::FLD_W];
                    end
                    lcg_pkg::ADDR_SOURCE: begin
                        wr = merge(pack3(st.cfg.reg_chain, st.cfg.counter, st.cfg.aclr_sel_b), i_wb_dat, i_wb_sel);
                        next_st.cfg.reg_chain = wr[lcg_pkg::FLD_A +: lcg_pkg::FLD_W];
                        next_st.cfg.counter = wr[lcg_pkg::FLD_B +: lcg_pkg::FLD_W];
                        next_st.cfg.aclr_sel_b = wr[lcg_pkg::FLD_C +: lcg_pkg::FLD_W];
                    end
                    lcg_pkg::ADDR_CHAIN: begin
                        wr = merge(pack3(st.cfg.chain_start, st.cfg.lut_chain, 10'h000), i_wb_dat, i_wb_sel);
                        next_st.cfg.chain_start = wr[lcg_pkg::FLD_A +: lcg_pkg::FLD_W];
                        next_st.cfg.lut_chain = wr[lcg_pkg::FLD_B +: lcg_pkg::FLD_W];
                    end
                    default: begin
                        // status and unmapped words ignore writes but still ack
                        if (slot != lcg_pkg::LUT_NONE) begin
                            wr = merge({16'h0000, st.cfg.lut_mask[slot]}, i_wb_dat, i_wb_sel);
                            next_st.cfg.lut_mask[slot] = wr[lcg_pkg::LUT_W-1:0];
                        end
                    end
                endcase
            end
        end
    end

    always_ff @(posedge i_mclk or negedge i_rstn) begin : state_reg
        if (!i_rstn) begin
            st <= lcg_pkg::STATE_RESET;
        end else begin
            st <= next_st;
        end
    end

    // all outputs come straight from the state register
    assign o_wb_dat = st.rdata;
    assign o_wb_ack = st.ack;
    assign o_cell_q = st.q;
    assign o_cell_comb = st.comb;
    assign o_carry_out = st.carry_out;
    assign o_lut_chain_out = st.lut_chain_out;
    assign o_reg_chain_out = st.q[lcg_pkg::NUM_CELLS-1];

    default clocking cb @(posedge i_mclk);
    endclocking
    default disable iff (!i_rstn);

    a_dev_clear_wins: assert property ( // RULE_20
        dev_clr |=> st.q == '0
    ) else $error("device clear left a register set");

    a_async_clear_first: assert property ( // RULE_18
        !dev_clr && cell_aclr[0] && i_group_ctrl.async_load |=> !st.q[0]
    ) else $error("async load beat async clear");

    a_async_load_data: assert property ( // RULE_07
        !dev_clr && !cell_aclr[0] && i_group_ctrl.async_load
        |=> st.q[0] == $past(i_cell_data[0].fourth_data_input)
    ) else $error("async load did not take the fourth input");

    a_sync_clear_prio: assert property ( // RULE_24
        !dev_clr && !cell_aclr[0] && !i_group_ctrl.async_load && cell_tick[0]
        && i_group_ctrl.sync_clear && i_group_ctrl.sync_load |=> !st.q[0]
    ) else $error("sync load beat sync clear");

    a_sync_load_data: assert property ( // RULE_16
        !dev_clr && !cell_aclr[3] && !i_group_ctrl.async_load && cell_tick[3]
        && !i_group_ctrl.sync_clear && i_group_ctrl.sync_load
        |=> st.q[3] == $past(i_cell_data[3].fourth_data_input)
    ) else $error("sync load missed a cell");

    a_hold_no_tick: assert property ( // RULE_22
        !dev_clr && !cell_aclr[2] && !i_group_ctrl.async_load && !cell_tick[2] |=> $stable(st.q[2])
    ) else $error("register moved without an enabled clock");

    a_reg_chain_shift: assert property ( // RULE_06
        !dev_clr && !cell_aclr[4] && !i_group_ctrl.async_load && cell_tick[4] && !i_group_ctrl.sync_clear
        && !i_group_ctrl.sync_load && st.cfg.reg_chain[4] && !st.cfg.counter[4]
        |=> st.q[4] == $past(st.q[3])
    ) else $error("register chain did not shift");

    a_add_full_width: assert property ( // RULE_01
        st.cfg.arith == '1 && st.cfg.chain_start == 10'h001 && st.cfg.counter == '0 && i_group_ctrl.add_sub
        |=> o_cell_comb == $past(add_sum)
    ) else $error("ten-bit add result wrong");

    a_add_carry_out: assert property ( // RULE_13
        st.cfg.arith == '1 && st.cfg.chain_start == 10'h001 && st.cfg.counter == '0 && i_group_ctrl.add_sub
        |=> o_carry_out == $past(add_cout)
    ) else $error("final carry-out wrong");

    a_sub_full_width: assert property ( // RULE_02
        st.cfg.arith == '1 && st.cfg.chain_start == 10'h001 && st.cfg.counter == '0 && !i_group_ctrl.add_sub
        |=> o_cell_comb == $past(sub_sum)
    ) else $error("ten-bit subtract result wrong");

    a_lut_lookup: assert property ( // RULE_04
        !st.cfg.arith[1] && !st.cfg.lut_chain[1] && !st.cfg.lut_carry[1] |=> o_cell_comb[1] == $past(lut1_ref)
    ) else $error("lookup output does not follow the mask");

endmodule : lcg_cell_group

// file: shared/lcg_pkg.sv
// constants, carrier types and register layout for the ten-cell logic group
// Functional notes
// RULE_01: add/subtract select picks A plus or minus B
// RULE_02: subtract inverts B, forces chain carry-in high
// RULE_03: adder LSB sits in chain's first cell
// RULE_04: normal mode: four-input lookup, carry may replace fourth
// RULE_05: lookup output chains to next cell's lookup
// RULE_06: register output feeds next cell's register input
// RULE_07: asynchronous load takes the fourth data input
// RULE_08: arithmetic cell precomputes sums and carries both ways
// RULE_09: group carry picks chain, chain picks sum
// RULE_10: each chain's carry selects that chain's carry-out
// RULE_11: carry selection regenerated at fifth and tenth cells; the code rebuilds it only once, from the fifth cell's carry-out (REGEN_CELL)
// RULE_12: chains start anywhere, continue into next group
// RULE_13: final carry-out delivered to a cell output
// RULE_14: sum available registered and unregistered
// RULE_15: counter enable and up/down from local data inputs
// RULE_16: synchronous clear and load act on whole group
// RULE_17: group controls in every mode, add/subtract in arithmetic
// RULE_18: preset is async load of one; clear wins
// RULE_19: two asynchronous clears and one preset per group
// RULE_20: enabled device-wide clear overrides every register control
// RULE_21: group holds ten cells with chains and controls
// RULE_22: group clock enable gates its paired clock
// RULE_23: device-wide clear is active low
// RULE_24: synchronous clear beats synchronous load
package lcg_pkg;

    localparam int NUM_CELLS = 10;
    // the carry selection is rebuilt entering this cell, i.e. from the fifth cell's carry-out
    localparam int REGEN_CELL = 5;
    localparam int SYNC_STAGES = 3;

    // register byte addresses
    localparam logic [7:0] ADDR_CTRL = 8'h00;
    localparam logic [7:0] ADDR_MODE = 8'h04;
    localparam logic [7:0] ADDR_SOURCE = 8'h08;
    localparam logic [7:0] ADDR_CHAIN = 8'h0c;
    localparam logic [7:0] ADDR_LUT_BASE = 8'h10;
    localparam logic [7:0] ADDR_STATUS = 8'h38;
    localparam logic [3:0] LUT_NONE = 4'hf;

    // field positions: the mode and source registers carry three ten-bit per-cell fields, the chain register two
    localparam int FLD_A = 0;
    localparam int FLD_B = 10;
    localparam int FLD_C = 20;
    localparam int FLD_W = 10;
    localparam int LUT_W = 16;
    localparam int CTRL_DEVCLR_BIT = 0;
    localparam int STAT_CARRY_BIT = 10;
    localparam int STAT_DEVCLR_BIT = 11;

    typedef struct packed {
        logic first_data_input;
        logic second_data_input;
        logic third_data_input;
        logic fourth_data_input;
    } lcg_cell_in_type;

    typedef struct packed {
        logic group_clock_a;
        logic group_clock_enable_a;
        logic group_clock_b;
        logic group_clock_enable_b;
        logic async_clear_a;
        logic async_clear_b;
        logic async_load;
        logic sync_clear;
        logic sync_load;
        logic add_sub;
    } lcg_ctrl_type;

    typedef struct packed {
        logic dev_clr_en;
        logic [NUM_CELLS-1:0] arith;
        logic [NUM_CELLS-1:0] lut_carry;
        logic [NUM_CELLS-1:0] clk_sel_b;
        logic [NUM_CELLS-1:0] reg_chain;
        logic [NUM_CELLS-1:0] counter;
        logic [NUM_CELLS-1:0] aclr_sel_b;
        logic [NUM_CELLS-1:0] chain_start;
        logic [NUM_CELLS-1:0] lut_chain;
        logic [NUM_CELLS-1:0][LUT_W-1:0] lut_mask;
    } lcg_cfg_type;

    typedef struct packed {
        lcg_cfg_type cfg;
        logic [NUM_CELLS-1:0] q;
        logic [NUM_CELLS-1:0] comb;
        logic carry_out;
        logic lut_chain_out;
        logic [SYNC_STAGES-1:0] dclr_sync;
        logic dclr_n;
        logic ack;
        logic [31:0] rdata;
    } lcg_state_type;

    // everything clears at reset; the device clear option is off so the zero sync value is harmless
    localparam lcg_state_type STATE_RESET = '0;

endpackage : lcg_pkg

// file: test/lcg_fabric_model.sv
// fabric-side model: spreads operand vectors over the data inputs of the ten cells
`timescale 1ns/100ps
module lcg_fabric_model (
    input wire logic [lcg_pkg::NUM_CELLS-1:0] i_a,
    input wire logic [lcg_pkg::NUM_CELLS-1:0] i_b,
    input wire logic [lcg_pkg::NUM_CELLS-1:0] i_c,
    input wire logic [lcg_pkg::NUM_CELLS-1:0] i_d,
    output lcg_pkg::lcg_cell_in_type [lcg_pkg::NUM_CELLS-1:0] o_cell_data
);
    // bit i of each operand lands in cell i, so an adder's lsb sits in the first cell when its chain starts there
    always_comb begin
        for (int i = 0; i < lcg_pkg::NUM_CELLS; i++) begin
            o_cell_data[i].first_data_input = i_a[i];
            o_cell_data[i].second_data_input = i_b[i];
            o_cell_data[i].third_data_input = i_c[i];
            o_cell_data[i].fourth_data_input = i_d[i];
        end
    end
endmodule : lcg_fabric_model

// file: test/tb_top.sv
// self-checking bench for the ten-cell logic group
`timescale 1ns/100ps
module tb_top;
    logic i_mclk;
    logic i_rstn;
    logic wb_cyc, wb_stb, wb_we, wb_ack;
    logic [7:0] wb_adr;
    logic [31:0] wb_wdat, wb_rdat;
    logic [9:0] op_a, op_b, op_c, op_d, cell_q, cell_comb;
    logic carry_in, lut_in, reg_in, dclr_n, carry_out, lut_out, reg_out;
    lcg_pkg::lcg_ctrl_type ctrl;
    lcg_pkg::lcg_cell_in_type [lcg_pkg::NUM_CELLS-1:0] cell_data;
    int n_errors = 0;
    int cmp_count = 0;
    // arithmetic vectors: a, b, add_sub, carry in
    logic [9:0] va [4] = '{10'h2a5, 10'h3ff, 10'h100, 10'h005};
    logic [9:0] vb [4] = '{10'h15b, 10'h000, 10'h001, 10'h00a};
    logic vs [4] = '{1'b1, 1'b1, 1'b0, 1'b0};
    logic vc [4] = '{1'b0, 1'b1, 1'b0, 1'b0};

    lcg_fabric_model lcg_fabric_model_i (.i_a(op_a), .i_b(op_b), .i_c(op_c), .i_d(op_d), .o_cell_data(cell_data));
    lcg_cell_group lcg_cell_group_i (.i_mclk(i_mclk), .i_rstn(i_rstn), .i_wb_cyc(wb_cyc), .i_wb_stb(wb_stb),
        .i_wb_we(wb_we), .i_wb_adr(wb_adr), .i_wb_dat(wb_wdat), .i_wb_sel(4'hf), .o_wb_dat(wb_rdat),
        .o_wb_ack(wb_ack), .i_cell_data(cell_data), .i_group_ctrl(ctrl), .i_group_carry_in(carry_in),
        .i_reg_chain_in(reg_in), .i_lut_chain_in(lut_in), .i_device_wide_clear_n(dclr_n),
        .o_cell_q(cell_q), .o_cell_comb(cell_comb), .o_carry_out(carry_out), .o_lut_chain_out(lut_out),
        .o_reg_chain_out(reg_out));

    // 200 MHz clock
    initial begin
        i_mclk = 1'b0;
        forever #2.5 i_mclk = ~i_mclk;
    end

    task automatic report_and_stop();
        $display("comparisons %0d mismatches %0d", cmp_count, n_errors);
        if (n_errors == 0 && cmp_count > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : report_and_stop

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            n_errors++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    // one classic wishbone cycle; ack is read before the edge's own updates land
    task automatic wb_cycle(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
        int n;
        n = 0;
        @(posedge i_mclk);
        {wb_cyc, wb_stb, wb_we} <= {2'b11, w};
        wb_adr <= a;
        wb_wdat <= d;
        @(posedge i_mclk);
        while (wb_ack !== 1'b1 && n < 20) begin
            @(posedge i_mclk);
            n++;
        end
        if (n >= 20) n_errors++;
        r = wb_rdat;
        {wb_cyc, wb_stb, wb_we} <= 3'b000;
    endtask : wb_cycle

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] r;
        wb_cycle(1'b1, a, d, r);
    endtask : wr

    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        logic [31:0] r;
        wb_cycle(1'b0, a, 32'h0, r);
        chk(r, exp);
    endtask : rd

    // let n edges pass, then sample once everything has settled
    task automatic wait_edges(input int n);
        repeat (n) @(posedge i_mclk);
        #1;
    endtask : wait_edges

    // watchdog: the tests need well under a thousand cycles
    initial begin
        #50000;
        n_errors++;
        report_and_stop();
    end

    initial begin
        logic [10:0] e;
        i_rstn = 1'b0;
        {wb_cyc, wb_stb, wb_we, wb_adr, wb_wdat} = '0;
        {op_a, op_b, op_c, op_d} = '0;
        {carry_in, lut_in, reg_in, dclr_n} = 4'b0001;
        ctrl = '0;
        repeat (2) @(posedge i_mclk);
        i_rstn <= 1'b1;
        rd(lcg_pkg::ADDR_MODE, 32'h0);
        rd(8'h3c, 32'h0);
        rd(8'h05, 32'h0);
        wr(lcg_pkg::ADDR_CHAIN, 32'h1);
        rd(lcg_pkg::ADDR_CHAIN, 32'h1);
        wr(lcg_pkg::ADDR_MODE, 32'h3ff);
        rd(lcg_pkg::ADDR_MODE, 32'h3ff);
        $display("test register access done");
        // add and subtract across the whole chain, carry through the regeneration point
        for (int k = 0; k < 4; k++) begin
            @(posedge i_mclk);
            {op_a, op_b, ctrl.add_sub, carry_in} <= {va[k], vb[k], vs[k], vc[k]};
            ctrl.group_clock_a <= 1'b1;
            ctrl.group_clock_enable_a <= 1'b1;
            wait_edges(1);
            e = {1'b0, va[k]} + {1'b0, vs[k] ? vb[k] : ~vb[k]} + {10'h0, vs[k] ? vc[k] : 1'b1};
            chk({21'h0, carry_out, cell_comb}, {21'h0, e});
            chk({22'h0, cell_q}, {22'h0, e[9:0]});
        end
        $display("test arithmetic done");
        @(posedge i_mclk);
        ctrl.group_clock_enable_a <= 1'b0;
        op_a <= 10'h000;
        wait_edges(2);
        chk({22'h0, cell_q}, 32'h3fb);
        @(posedge i_mclk);
        {ctrl.group_clock_enable_a, ctrl.sync_clear, ctrl.sync_load} <= 3'b111;
        op_d <= 10'h155;
        wait_edges(1);
        chk({22'h0, cell_q}, 32'h0);
        ctrl.sync_clear <= 1'b0;
        wait_edges(1);
        chk({22'h0, cell_q}, 32'h155);
        {ctrl.group_clock_enable_a, ctrl.sync_load, ctrl.async_load} <= 3'b001;
        op_d <= 10'h0f0;
        wait_edges(1);
        chk({22'h0, cell_q}, 32'h0f0);
        ctrl.async_clear_a <= 1'b1;
        wait_edges(1);
        chk({22'h0, cell_q}, 32'h0);
        ctrl.async_clear_a <= 1'b0;
        op_d <= 10'h3ff;
        wait_edges(1);
        chk({22'h0, cell_q}, 32'h3ff);
        chk({31'h0, reg_out}, 32'h1);
        ctrl.async_load <= 1'b0;
        $display("test register controls done");
        // device clear option on; filtered pin needs five edges to reach the registers
        wr(lcg_pkg::ADDR_CTRL, 32'h1);
        @(posedge i_mclk);
        dclr_n <= 1'b0;
        wait_edges(6);
        chk({22'h0, cell_q}, 32'h0);
        dclr_n <= 1'b1;
        wait_edges(6);
        wr(lcg_pkg::ADDR_CTRL, 32'h0);
        $display("test device clear done");
        // normal mode: every mask is the and of all four inputs
        wr(lcg_pkg::ADDR_MODE, 32'h0);
        wr(lcg_pkg::ADDR_CHAIN, 32'h0);
        for (int i = 0; i < lcg_pkg::NUM_CELLS; i++) wr(8'(lcg_pkg::ADDR_LUT_BASE + 4 * i), 32'h8000);
        @(posedge i_mclk);
        {op_a, op_b, op_c, op_d} <= {10'h3ff, 10'h3f0, 10'h3cc, 10'h3aa};
        wait_edges(1);
        chk({22'h0, cell_comb}, 32'h380);
        wr(lcg_pkg::ADDR_CHAIN, 32'h000ffc00);
        {op_a, op_b, op_c, op_d, lut_in} <= {10'h000, 10'h3ff, 10'h3ff, 10'h3ff, 1'b1};
        wait_edges(1);
        chk({21'h0, lut_out, cell_comb}, 32'h7ff);
        $display("test lookup chain done");
        wr(lcg_pkg::ADDR_SOURCE, 32'h3ff);
        ctrl.group_clock_enable_a <= 1'b1;
        reg_in <= 1'b1;
        wait_edges(3);
        chk({22'h0, cell_q}, 32'h007);
        ctrl.group_clock_enable_a <= 1'b0;
        $display("test register chain done");
        // counter: own q plus or minus one, direction and enable from local data inputs
        wr(lcg_pkg::ADDR_SOURCE, 32'h000ffc00);
        wr(lcg_pkg::ADDR_MODE, 32'h3ff);
        wr(lcg_pkg::ADDR_CHAIN, 32'h1);
        @(posedge i_mclk);
        {op_b, op_c} <= {10'h3ff, 10'h3ff};
        ctrl.group_clock_enable_a <= 1'b1;
        wait_edges(4);
        chk({22'h0, cell_q}, 32'h00b);
        op_b <= 10'h000;
        wait_edges(2);
        chk({22'h0, cell_q}, 32'h009);
        op_c <= 10'h000;
        wait_edges(2);
        chk({22'h0, cell_q}, 32'h009);
        $display("test counter done");
        report_and_stop();
    end
endmodule : tb_top
